/* ifs_apb_decode.sv */
// module: APB address decoder and phase strobes for the flag bank
`timescale 1ns/1ps
module ifs_apb_decode (
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [ifs_pkg::ADDR_W-1:0]     paddr,
  output logic      [ifs_pkg::NUM_REGS-1:0]   regSel,
  output logic                                addrHit,
  output logic                                setupRd,
  output logic                                accessWr,
  output logic                                setupPhase
);

  always_comb begin
    regSel = '0;
    unique case (paddr)
      ifs_pkg::OFS_FLAG_WORD:   regSel[ifs_pkg::SEL_FLAG_WORD]   = 1'b1;
      ifs_pkg::OFS_FLAG_SET:    regSel[ifs_pkg::SEL_FLAG_SET]    = 1'b1;
      ifs_pkg::OFS_FLAG_CLR:    regSel[ifs_pkg::SEL_FLAG_CLR]    = 1'b1;
      ifs_pkg::OFS_INT_STATUS:  regSel[ifs_pkg::SEL_INT_STATUS]  = 1'b1;
      ifs_pkg::OFS_INT_MASK:    regSel[ifs_pkg::SEL_INT_MASK]    = 1'b1;
      ifs_pkg::OFS_LINE_CTRL:   regSel[ifs_pkg::SEL_LINE_CTRL]   = 1'b1;
      ifs_pkg::OFS_EVENT_COUNT: regSel[ifs_pkg::SEL_EVENT_COUNT] = 1'b1;
      ifs_pkg::OFS_LINE_STATE:  regSel[ifs_pkg::SEL_LINE_STATE]  = 1'b1;
      default:                  regSel = '0;
    endcase
  end

  assign addrHit    = |regSel;
  assign setupPhase = psel & ~penable;
  assign setupRd    = setupPhase & ~pwrite;
  // writes land only at the completing access edge, and only on a mapped word
  assign accessWr   = psel & penable & pwrite & addrHit;

endmodule // ifs_apb_decode

/* ifs_ext_edge.sv */
// module: two-flop synchroniser and edge detector for the external request pin
`timescale 1ns/1ps
module ifs_ext_edge (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic pinIn,
  input  wire logic fallingSel,
  input  wire logic enable,
  output logic      lineLevel,
  output logic      edgePulse
);

  logic syncA_q;
  logic syncB_q;
  logic prev_q;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      syncA_q <= 1'b0;
      syncB_q <= 1'b0;
      prev_q  <= 1'b0;
    end else begin
      syncA_q <= pinIn;
      syncB_q <= syncA_q;
      prev_q  <= syncB_q;
    end
  end

  assign lineLevel = syncB_q;
  // one pulse per selected edge of the settled level
  assign edgePulse = enable & (fallingSel ? (prev_q & ~syncB_q) : (~prev_q & syncB_q));

endmodule // ifs_ext_edge

/* ifs_flag_bank.sv */
// module: interrupt request flag word with APB access, interrupt status and mask
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module ifs_flag_bank (
  input  wire logic                       core_clk,
  input  wire logic                       sys_rst,
  // APB slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [ifs_pkg::ADDR_W-1:0] paddr,
  input  wire logic [ifs_pkg::DATA_W-1:0] pwdata,
  output logic      [ifs_pkg::DATA_W-1:0] prdata,
  output logic                            pready,
  output logic                            pslverr,
  // peripheral request pulses, same clock
  input  wire logic                       converterReq,
  input  wire logic                       serialTxReq,
  input  wire logic                       serialRxReq,
  input  wire logic                       spiEventReq,
  input  wire logic                       spiFaultReq,
  input  wire logic                       timerCReq,
  input  wire logic                       timerBReq,
  input  wire logic                       timerAReq,
  input  wire logic                       compareBReq,
  input  wire logic                       compareAReq,
  input  wire logic                       captureBReq,
  input  wire logic                       captureAReq,
  // external request pin, asynchronous
  input  wire logic                       extLine0Pin,
  // flag word and interrupt
  output logic      [ifs_pkg::FLAG_W-1:0] irqFlagWord,
  output logic                            irqOut
);

  logic [ifs_pkg::FLAG_W-1:0]   flags_q;
  logic [ifs_pkg::FLAG_W-1:0]   flags_d;
  logic [ifs_pkg::FLAG_W-1:0]   intStatus_q;
  logic [ifs_pkg::FLAG_W-1:0]   intStatus_d;
  logic [ifs_pkg::FLAG_W-1:0]   intMask_q;
  logic [1:0]                   lineCtrl_q;
  logic [ifs_pkg::FLAG_W-1:0]   eventCount_q;
  logic [ifs_pkg::DATA_W-1:0]   rdData_q;
  logic                         slvErr_q;
  logic [ifs_pkg::DATA_W-1:0]   rdMux;
  logic [ifs_pkg::FLAG_W-1:0]   eventVec;
  logic [ifs_pkg::FLAG_W-1:0]   wrFlags;
  logic [ifs_pkg::NUM_REGS-1:0] regSel;
  logic                         addrHit;
  logic                         setupRd;
  logic                         accessWr;
  logic                         setupPhase;
  logic                         extLevel;
  logic                         extEdge;
  logic                         anyEvent;

  // ---------------------------------------------------------------
  // bus front end
  // ---------------------------------------------------------------
  ifs_apb_decode u_decode (
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .paddr      (paddr),
    .regSel     (regSel),
    .addrHit    (addrHit),
    .setupRd    (setupRd),
    .accessWr   (accessWr),
    .setupPhase (setupPhase)
  );

  // ---------------------------------------------------------------
  // external line: synchronised, edge selected by control register
  // ---------------------------------------------------------------
  ifs_ext_edge u_ext0 (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .pinIn      (extLine0Pin),
    .fallingSel (lineCtrl_q[ifs_pkg::BIT_EXT_FALLING]),
    .enable     (lineCtrl_q[ifs_pkg::BIT_EXT_ENABLE]),
    .lineLevel  (extLevel),
    .edgePulse  (extEdge)
  );

  // ---------------------------------------------------------------
  // request vector in flag-word layout
  // ---------------------------------------------------------------
  always_comb begin
    eventVec                              = '0;
    eventVec[ifs_pkg::BIT_CONVERTER]      = converterReq;
    eventVec[ifs_pkg::BIT_SERIAL_TX]      = serialTxReq;
    eventVec[ifs_pkg::BIT_SERIAL_RX]      = serialRxReq;
    eventVec[ifs_pkg::BIT_SPI_EVENT]      = spiEventReq;
    eventVec[ifs_pkg::BIT_SPI_FAULT]      = spiFaultReq;
    eventVec[ifs_pkg::BIT_TIMER_C]        = timerCReq;
    eventVec[ifs_pkg::BIT_TIMER_B]        = timerBReq;
    eventVec[ifs_pkg::BIT_COMPARE_B]      = compareBReq;
    eventVec[ifs_pkg::BIT_CAPTURE_B]      = captureBReq;
    eventVec[ifs_pkg::BIT_TIMER_A]        = timerAReq;
    eventVec[ifs_pkg::BIT_COMPARE_A]      = compareAReq;
    eventVec[ifs_pkg::BIT_CAPTURE_A]      = captureAReq;
    eventVec[ifs_pkg::BIT_EXT_LINE0]      = extEdge;
  end

  assign anyEvent = |eventVec;
  assign wrFlags  = ifs_pkg::implBits(pwdata[ifs_pkg::FLAG_W-1:0]);

  // ---------------------------------------------------------------
  // flag word: direct write, set and clear aliases, events on top
  // ---------------------------------------------------------------
  always_comb begin
    flags_d = flags_q;
    if (accessWr && regSel[ifs_pkg::SEL_FLAG_WORD]) begin
      // a zero written clears the flag, a one forces a request
      flags_d = wrFlags;
    end
    if (accessWr && regSel[ifs_pkg::SEL_FLAG_SET]) begin
      flags_d = flags_q | wrFlags;
    end
    if (accessWr && regSel[ifs_pkg::SEL_FLAG_CLR]) begin
      flags_d = flags_q & ~wrFlags;
    end
    // a source event in the same cycle overrides any clear
    flags_d = ifs_pkg::implBits(flags_d | eventVec);
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      flags_q <= ifs_pkg::RST_FLAG_WORD;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign irqFlagWord = flags_q;

  // ---------------------------------------------------------------
  // interrupt status: sticky per source, write one to clear
  // ---------------------------------------------------------------
  always_comb begin
    intStatus_d = intStatus_q;
    if (accessWr && regSel[ifs_pkg::SEL_INT_STATUS]) begin
      intStatus_d = intStatus_q & ~wrFlags;
    end
    // a new event beats the clear of its status bit
    intStatus_d = ifs_pkg::implBits(intStatus_d | eventVec);
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      intStatus_q <= ifs_pkg::RST_INT_STATUS;
    end else begin
      intStatus_q <= intStatus_d;
    end
  end

  // ---------------------------------------------------------------
  // interrupt mask
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      intMask_q <= ifs_pkg::RST_INT_MASK;
    end else if (accessWr && regSel[ifs_pkg::SEL_INT_MASK]) begin
      intMask_q <= wrFlags;
    end
  end

  // level output, high while any unmasked status bit is set
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irqOut <= 1'b0;
    end else begin
      irqOut <= |(intStatus_d & intMask_q);
    end
  end

  // ---------------------------------------------------------------
  // external line control: edge polarity and enable
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lineCtrl_q <= ifs_pkg::RST_LINE_CTRL;
    end else if (accessWr && regSel[ifs_pkg::SEL_LINE_CTRL]) begin
      lineCtrl_q <= pwdata[1:0];
    end
  end

  // ---------------------------------------------------------------
  // event counter: cycles with at least one request, saturating
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      eventCount_q <= ifs_pkg::RST_EVENT_COUNT;
    end else if (accessWr && regSel[ifs_pkg::SEL_EVENT_COUNT]) begin
      // any write restarts the count; an event in that cycle is counted
      eventCount_q <= {15'h0000, anyEvent};
    end else if (anyEvent && (eventCount_q != ifs_pkg::COUNT_MAX)) begin
      eventCount_q <= eventCount_q + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // read path: word captured in the setup cycle, shown in access
  // ---------------------------------------------------------------
  always_comb begin
    rdMux = '0;
    unique case (1'b1)
      regSel[ifs_pkg::SEL_FLAG_WORD],
      regSel[ifs_pkg::SEL_FLAG_SET],
      regSel[ifs_pkg::SEL_FLAG_CLR]: begin
        rdMux[ifs_pkg::FLAG_W-1:0] = ifs_pkg::implBits(flags_q);
      end
      regSel[ifs_pkg::SEL_INT_STATUS]: begin
        rdMux[ifs_pkg::FLAG_W-1:0] = ifs_pkg::implBits(intStatus_q);
      end
      regSel[ifs_pkg::SEL_INT_MASK]: begin
        rdMux[ifs_pkg::FLAG_W-1:0] = ifs_pkg::implBits(intMask_q);
      end
      regSel[ifs_pkg::SEL_LINE_CTRL]: begin
        rdMux[1:0] = lineCtrl_q;
      end
      regSel[ifs_pkg::SEL_EVENT_COUNT]: begin
        rdMux[ifs_pkg::FLAG_W-1:0] = eventCount_q;
      end
      regSel[ifs_pkg::SEL_LINE_STATE]: begin
        rdMux[0] = extLevel;
        rdMux[1] = irqOut;
      end
      default: begin
        rdMux = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rdData_q <= '0;
    end else if (setupRd) begin
      rdData_q <= rdMux;
    end else if (setupPhase) begin
      rdData_q <= '0;
    end
  end

  // unmapped words answer with an error, reads there return zero
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      slvErr_q <= 1'b0;
    end else if (setupPhase) begin
      slvErr_q <= ~addrHit;
    end
  end

  // zero wait states: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign prdata  = rdData_q;
  assign pslverr = slvErr_q & psel & penable;

endmodule // ifs_flag_bank

/* ifs_flag_bank_monitor.sv */
// checker: timing properties of the flag bank seen at its top ports
`timescale 1ns/1ps
module ifs_flag_bank_monitor (
  input wire logic                       core_clk,
  input wire logic                       sys_rst,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [ifs_pkg::ADDR_W-1:0] paddr,
  input wire logic [ifs_pkg::DATA_W-1:0] pwdata,
  input wire logic                       serialRxReq,
  input wire logic                       spiEventReq,
  input wire logic                       spiFaultReq,
  input wire logic                       timerCReq,
  input wire logic                       timerBReq,
  input wire logic                       compareBReq,
  input wire logic                       captureBReq,
  input wire logic                       extLine0Pin,
  input wire logic [ifs_pkg::FLAG_W-1:0] irqFlagWord
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // bus-side copy of the edge selection: which pin edge must raise the flag
  logic [1:0] lineCtrlSeen_q;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lineCtrlSeen_q <= ifs_pkg::RST_LINE_CTRL;
    end else if (psel && penable && pwrite && paddr == ifs_pkg::OFS_LINE_CTRL) begin
      lineCtrlSeen_q <= pwdata[1:0];
    end
  end

  sequence s_flagWrite;
    psel && penable && pwrite && paddr == ifs_pkg::OFS_FLAG_WORD;
  endsequence
  sequence s_rxQuiet;
    !serialRxReq && !pwdata[11];
  endsequence

  a_rx_set: assert property (serialRxReq |=> irqFlagWord[11])
    else $error("rx flag not set");
  a_spi_event_set: assert property (spiEventReq |=> irqFlagWord[10])
    else $error("spi event flag not set");
  a_spi_fault_set: assert property (spiFaultReq |=> irqFlagWord[9])
    else $error("spi fault flag not set");
  a_timer_c_set: assert property (timerCReq |=> irqFlagWord[8])
    else $error("timer c flag not set");
  a_timer_b_set: assert property (timerBReq |=> irqFlagWord[7])
    else $error("timer b flag not set");
  a_compare_b_set: assert property (compareBReq |=> irqFlagWord[6])
    else $error("compare b flag not set");
  a_capture_b_set: assert property (captureBReq |=> irqFlagWord[5])
    else $error("capture b flag not set");
  a_ext_flag_set: assert property ((lineCtrlSeen_q == 2'h2 && $rose(extLine0Pin)) |-> ##[2:4] irqFlagWord[0])
    else $error("ext line flag late");
  a_ext_fall_set: assert property ((lineCtrlSeen_q == 2'h3 && $fell(extLine0Pin)) |-> ##[2:4] irqFlagWord[0])
    else $error("ext line falling flag late");
  a_rx_sw_clear: assert property ((s_flagWrite and s_rxQuiet) |=> !irqFlagWord[11])
    else $error("rx flag not cleared");
  a_reset_zero: assert property (disable iff (1'b0) sys_rst |=> irqFlagWord == 16'h0000)
    else $error("flags not zero after reset");
endmodule // ifs_flag_bank_monitor

bind ifs_flag_bank ifs_flag_bank_monitor u_ifs_flag_bank_monitor (
  .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .serialRxReq(serialRxReq),
  .spiEventReq(spiEventReq), .spiFaultReq(spiFaultReq), .timerCReq(timerCReq),
  .timerBReq(timerBReq), .compareBReq(compareBReq), .captureBReq(captureBReq),
  .extLine0Pin(extLine0Pin), .irqFlagWord(irqFlagWord)
);

/* ifs_flag_bank_test.sv */
// testbench: register access, events, clear race, interrupt and pin of the flag bank
`timescale 1ns/1ps
module ifs_flag_bank_test;
  logic        core_clk;
  logic        sys_rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [11:0] reqVec;
  logic        extLine0Pin;
  logic [15:0] irqFlagWord;
  logic        irqOut;
  logic [31:0] rdData;
  logic        rdErr;
  int          errors;
  int          samples_checked;
  int          bitOf [12];

  ifs_flag_bank u_ifs_flag_bank (
    .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .converterReq(reqVec[0]), .serialTxReq(reqVec[1]),
    .serialRxReq(reqVec[2]), .spiEventReq(reqVec[3]), .spiFaultReq(reqVec[4]),
    .timerCReq(reqVec[5]), .timerBReq(reqVec[6]), .compareBReq(reqVec[7]),
    .captureBReq(reqVec[8]), .timerAReq(reqVec[9]), .compareAReq(reqVec[10]),
    .captureAReq(reqVec[11]), .extLine0Pin(extLine0Pin), .irqFlagWord(irqFlagWord),
    .irqOut(irqOut)
  );

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic summarize();
    if (errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one transfer; ev >= 0 raises that request during the access cycle
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data,
                     input int ev);
    int   n;
    logic rdy;
    n = 0;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= addr;
    pwdata <= data;
    @(posedge core_clk);
    penable <= 1'b1;
    if (ev >= 0) reqVec[ev] <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      rdData = prdata;
      rdErr  = pslverr;
      rdy    = pready;
    end while (rdy !== 1'b1 && n < 20);
    if (rdy !== 1'b1) begin
      errors++;
      $display("[FAIL] %0t no pready", $time);
      summarize();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    reqVec  <= '0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    apb(1'b1, addr, data, -1);
  endtask

  task automatic rd(input logic [7:0] addr);
    apb(1'b0, addr, 32'h00000000, -1);
  endtask

  task automatic pulse(input int idx);
    reqVec[idx] <= 1'b1;
    @(posedge core_clk);
    reqVec[idx] <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic t_reset();
    rd(ifs_pkg::OFS_FLAG_WORD);
    check(rdData, 32'h00000000);
    rd(ifs_pkg::OFS_INT_MASK);
    check(rdData, 32'h00000000);
    rd(ifs_pkg::OFS_LINE_CTRL);
    check(rdData, {30'h00000000, ifs_pkg::RST_LINE_CTRL});
  endtask

  task automatic t_events();
    for (int i = 0; i < 12; i++) begin
      pulse(i);
      rd(ifs_pkg::OFS_FLAG_WORD);
      check(rdData, 32'h00000001 << bitOf[i]);
      wr(ifs_pkg::OFS_FLAG_WORD, 32'h00000000);
      rd(ifs_pkg::OFS_FLAG_WORD);
      check(rdData, 32'h00000000);
    end
  endtask

  task automatic t_writable();
    wr(ifs_pkg::OFS_FLAG_WORD, 32'h0000FFFF);
    rd(ifs_pkg::OFS_FLAG_WORD);
    check(rdData, {16'h0000, ifs_pkg::FLAG_IMPL_MASK});
    check({16'h0000, irqFlagWord}, {16'h0000, ifs_pkg::FLAG_IMPL_MASK});
    wr(ifs_pkg::OFS_FLAG_WORD, 32'h00000000);
  endtask

  task automatic t_alias();
    wr(ifs_pkg::OFS_FLAG_SET, 32'h00000801);
    rd(ifs_pkg::OFS_FLAG_CLR);
    check(rdData, 32'h00000801);
    wr(ifs_pkg::OFS_FLAG_CLR, 32'h00000001);
    rd(ifs_pkg::OFS_FLAG_SET);
    check(rdData, 32'h00000800);
    wr(ifs_pkg::OFS_FLAG_CLR, 32'h00000800);
    wr(ifs_pkg::OFS_EVENT_COUNT, 32'h00000000);
    pulse(0);
    pulse(5);
    rd(ifs_pkg::OFS_EVENT_COUNT);
    check(rdData, 32'h00000002);
    rd(ifs_pkg::OFS_FLAG_WORD);
    check(rdData, 32'h00002100);
    wr(ifs_pkg::OFS_FLAG_WORD, 32'h00000000);
  endtask

  task automatic t_race();
    pulse(2);
    pulse(3);
    apb(1'b1, ifs_pkg::OFS_FLAG_WORD, 32'h00000000, 2);
    rd(ifs_pkg::OFS_FLAG_WORD);
    check(rdData, 32'h00000800);
    wr(ifs_pkg::OFS_FLAG_WORD, 32'h00000000);
    rd(ifs_pkg::OFS_FLAG_WORD);
    check(rdData, 32'h00000000);
  endtask

  task automatic t_unmapped();
    wr(8'h20, 32'h0000FFFF);
    rd(8'h20);
    check(rdData, 32'h00000000);
    check({31'h00000000, rdErr}, 32'h00000001);
    rd(ifs_pkg::OFS_FLAG_WORD);
    check(rdData, 32'h00000000);
    check({31'h00000000, rdErr}, 32'h00000000);
  endtask

  task automatic t_irq();
    wr(ifs_pkg::OFS_INT_STATUS, 32'h0000FFFF);
    wr(ifs_pkg::OFS_INT_MASK, 32'h00000800);
    pulse(2);
    @(negedge core_clk);
    check({31'h00000000, irqOut}, 32'h00000001);
    @(posedge core_clk);
    wr(ifs_pkg::OFS_INT_MASK, 32'h00000000);
    @(negedge core_clk);
    check({31'h00000000, irqOut}, 32'h00000000);
    @(posedge core_clk);
    wr(ifs_pkg::OFS_INT_MASK, 32'h00000800);
    @(negedge core_clk);
    check({31'h00000000, irqOut}, 32'h00000001);
    @(posedge core_clk);
    wr(ifs_pkg::OFS_INT_STATUS, 32'h00000800);
    @(negedge core_clk);
    check({31'h00000000, irqOut}, 32'h00000000);
    @(posedge core_clk);
    wr(ifs_pkg::OFS_FLAG_WORD, 32'h00000000);
  endtask

  task automatic t_ext();
    extLine0Pin <= 1'b1;
    repeat (6) @(posedge core_clk);
    rd(ifs_pkg::OFS_LINE_STATE);
    check(rdData, 32'h00000001);
    rd(ifs_pkg::OFS_FLAG_WORD);
    check(rdData, 32'h00000001);
    extLine0Pin <= 1'b0;
    repeat (6) @(posedge core_clk);
    wr(ifs_pkg::OFS_FLAG_WORD, 32'h00000000);
    rd(ifs_pkg::OFS_FLAG_WORD);
    check(rdData, 32'h00000000);
    // falling edge selected: a rising edge leaves the flag alone
    wr(ifs_pkg::OFS_LINE_CTRL, 32'h00000003);
    extLine0Pin <= 1'b1;
    repeat (6) @(posedge core_clk);
    rd(ifs_pkg::OFS_FLAG_WORD);
    check(rdData, 32'h00000000);
    extLine0Pin <= 1'b0;
    repeat (6) @(posedge core_clk);
    rd(ifs_pkg::OFS_FLAG_WORD);
    check(rdData, 32'h00000001);
    wr(ifs_pkg::OFS_FLAG_WORD, 32'h00000000);
    // line disabled: no edge raises the flag
    wr(ifs_pkg::OFS_LINE_CTRL, 32'h00000000);
    extLine0Pin <= 1'b1;
    repeat (6) @(posedge core_clk);
    extLine0Pin <= 1'b0;
    repeat (6) @(posedge core_clk);
    rd(ifs_pkg::OFS_FLAG_WORD);
    check(rdData, 32'h00000000);
  endtask

  initial begin
    bitOf = '{ifs_pkg::BIT_CONVERTER, ifs_pkg::BIT_SERIAL_TX, ifs_pkg::BIT_SERIAL_RX,
              ifs_pkg::BIT_SPI_EVENT, ifs_pkg::BIT_SPI_FAULT, ifs_pkg::BIT_TIMER_C,
              ifs_pkg::BIT_TIMER_B, ifs_pkg::BIT_COMPARE_B, ifs_pkg::BIT_CAPTURE_B,
              ifs_pkg::BIT_TIMER_A, ifs_pkg::BIT_COMPARE_A, ifs_pkg::BIT_CAPTURE_A};
    errors = 0;
    samples_checked = 0;
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    reqVec = 12'h000;
    extLine0Pin = 1'b0;
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    t_reset();
    t_events();
    t_writable();
    t_race();
    t_unmapped();
    t_alias();
    t_irq();
    t_ext();
    summarize();
  end
endmodule // ifs_flag_bank_test

/* ifs_pkg.sv */
// package: register map, field positions and reset values of the interrupt flag bank
package ifs_pkg;

  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned FLAG_W   = 16;
  localparam int unsigned NUM_REGS = 8;

  // register byte offsets
  localparam logic [7:0] OFS_FLAG_WORD   = 8'h00;
  localparam logic [7:0] OFS_FLAG_SET    = 8'h04;
  localparam logic [7:0] OFS_FLAG_CLR    = 8'h08;
  localparam logic [7:0] OFS_INT_STATUS  = 8'h0C;
  localparam logic [7:0] OFS_INT_MASK    = 8'h10;
  localparam logic [7:0] OFS_LINE_CTRL   = 8'h14;
  localparam logic [7:0] OFS_EVENT_COUNT = 8'h18;
  localparam logic [7:0] OFS_LINE_STATE  = 8'h1C;

  // one-hot select index of each register
  localparam int unsigned SEL_FLAG_WORD   = 0;
  localparam int unsigned SEL_FLAG_SET    = 1;
  localparam int unsigned SEL_FLAG_CLR    = 2;
  localparam int unsigned SEL_INT_STATUS  = 3;
  localparam int unsigned SEL_INT_MASK    = 4;
  localparam int unsigned SEL_LINE_CTRL   = 5;
  localparam int unsigned SEL_EVENT_COUNT = 6;
  localparam int unsigned SEL_LINE_STATE  = 7;

  // bit positions inside the flag word
  localparam int unsigned BIT_CONVERTER   = 13;
  localparam int unsigned BIT_SERIAL_TX   = 12;
  localparam int unsigned BIT_SERIAL_RX   = 11;
  localparam int unsigned BIT_SPI_EVENT   = 10;
  localparam int unsigned BIT_SPI_FAULT   = 9;
  localparam int unsigned BIT_TIMER_C     = 8;
  localparam int unsigned BIT_TIMER_B     = 7;
  localparam int unsigned BIT_COMPARE_B   = 6;
  localparam int unsigned BIT_CAPTURE_B   = 5;
  localparam int unsigned BIT_TIMER_A     = 3;
  localparam int unsigned BIT_COMPARE_A   = 2;
  localparam int unsigned BIT_CAPTURE_A   = 1;
  localparam int unsigned BIT_EXT_LINE0   = 0;

  // control register fields
  localparam int unsigned BIT_EXT_FALLING = 0;
  localparam int unsigned BIT_EXT_ENABLE  = 1;

  // implemented flag bits: 15, 14 and 4 read as zero
  localparam logic [15:0] FLAG_IMPL_MASK  = 16'h3FEF;

  // values after reset
  localparam logic [15:0] RST_FLAG_WORD   = 16'h0000;
  localparam logic [15:0] RST_INT_STATUS  = 16'h0000;
  localparam logic [15:0] RST_INT_MASK    = 16'h0000;
  localparam logic [1:0]  RST_LINE_CTRL   = 2'h2;
  localparam logic [15:0] RST_EVENT_COUNT = 16'h0000;
  localparam logic [15:0] COUNT_MAX       = 16'hFFFF;

  // keeps only the implemented flag positions
  function automatic logic [15:0] implBits(input logic [15:0] value);
    return value & FLAG_IMPL_MASK;
  endfunction

endpackage
